/* verilog/ssd_pkg.sv */
//======================================================================
// Summary of operation
// [RL1] initial state refuses mailbox and process data
// [RL2] guarded run: traffic accepted, outputs held safe
// [RL3] watchdog disabled: guarded run drives outputs
// [RL4] master sends output data before running
// [RL5] running: outputs follow master data
// [RL6] firmware update entered only from initial state
// [RL7] firmware update: file transfer mailbox only
// [RL8] entries addressed by 16-bit index, 8-bit subindex
// [RL9] entry attribute decides read or write access
// [RL10] identity and mapping data from 0x1000
// [RL11] channel parameters at 0x8000 or 0x4000
// [RL12] inputs at 0x6000, outputs at 0x7000
// [RL13] channel blocks sixteen indices apart
// [RL14] written parameters committed to nonvolatile memory
// [RL15] code word at 0xF008 enables save suppression
// [RL16] suppression: apply values, skip nonvolatile write
// [RL17] master limits rewrites without suppression
// [RL18] master replays start-up parameter list
// [RL19] illegal write aborts, dictionary unchanged
`default_nettype none
package ssd_pkg;
  //====================================================================
  // states and entry kinds
  typedef enum logic [2:0] {
    SSD_INIT_STATE,
    SSD_MAILBOX_ONLY_STATE,
    SSD_GUARDED_RUN_STATE,
    SSD_RUNNING_STATE,
    SSD_FW_UPDATE_STATE
  } ssd_state_t;

  typedef enum logic [2:0] {
    SSD_K_NONE,
    SSD_K_CONST,
    SSD_K_CHAN,
    SSD_K_PD_IN,
    SSD_K_PD_OUT,
    SSD_K_SAVE_CODE
  } ssd_kind_t;

  typedef struct packed {
    ssd_kind_t   kind;
    logic [7:0]  slot;
    logic [31:0] value;
  } ssd_entry_t;

  //====================================================================
  // addressing
  localparam int          IDX_W            = 16;
  localparam int          SUB_W            = 8;
  localparam int          DATA_W           = 32;
  localparam logic [15:0] IDX_DEV_TYPE     = 16'h1000;
  localparam logic [15:0] IDX_IDENTITY     = 16'h1018;
  localparam logic [15:0] IDX_OUT_MAP      = 16'h1600;
  localparam logic [15:0] IDX_IN_MAP       = 16'h1A00;
  localparam logic [15:0] IDX_CHAN_BASE    = 16'h8000;
  localparam logic [15:0] IDX_CHAN_ALT     = 16'h4000;
  localparam logic [15:0] IDX_PD_IN_BASE   = 16'h6000;
  localparam logic [15:0] IDX_PD_OUT_BASE  = 16'h7000;
  localparam logic [15:0] IDX_SAVE_CTRL    = 16'hF008;
  localparam int          CHAN_SHIFT       = 4;
  localparam logic [7:0]  SUB_ZERO         = 8'h00;
  localparam logic [7:0]  SUB_VENDOR       = 8'h01;
  localparam logic [7:0]  SUB_PRODUCT      = 8'h02;
  localparam logic [7:0]  SUB_PD_VALUE     = 8'h01;
  localparam logic [7:0]  SUB_CHAN_FIRST   = 8'h01;

  //====================================================================
  // values and reset values
  localparam logic [31:0] SAVE_CODE_WORD   = 32'h12345678;
  localparam logic [31:0] SAVE_CODE_RST    = 32'h00000000;
  localparam logic [31:0] PD_MAP_COUNT     = 32'h00000001;
  localparam logic        OUT_SAFE_LEVEL   = 1'b0;
  localparam ssd_state_t  SSD_RESET_STATE  = SSD_INIT_STATE;
endpackage : ssd_pkg
`default_nettype wire

/* verilog/ssd_param_ram.sv */
`default_nettype none
module ssd_param_ram #(
  parameter int DW    = 32,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  import ssd_pkg::*;

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end
endmodule : ssd_param_ram
`default_nettype wire

/* verilog/ssd_nvm_commit.sv */
`default_nettype none
module ssd_nvm_commit #(
  parameter int DW    = 32,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // commit request
  input  wire logic          commitStart,
  input  wire logic [AW-1:0] commitAddr,
  input  wire logic [DW-1:0] commitData,
  output logic               busy,
  // restore into dictionary
  output logic               loadWe,
  output logic      [AW-1:0] loadAddr,
  output logic      [DW-1:0] loadData,
  // nonvolatile memory
  output logic               nvmReq,
  output logic               nvmWrite,
  output logic      [AW-1:0] nvmAddr,
  output logic      [DW-1:0] nvmWdata,
  input  wire logic          nvmAck,
  input  wire logic [DW-1:0] nvmRdata
);
  import ssd_pkg::*;

  typedef enum logic [1:0] {NV_LOAD, NV_IDLE, NV_WRITE} ssd_nvm_phase_t;
  typedef struct packed {
    ssd_nvm_phase_t  ph;
    logic            req;
    logic            write;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   data;
    logic            busy;
    logic            loadWe;
  } ssd_nvm_t;

  localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);
  localparam ssd_nvm_t RST_VAL = '{ph: NV_LOAD, req: 1'b1, busy: 1'b1, default: '0};

  ssd_nvm_t r;
  ssd_nvm_t n;

  //====================================================================
  // restore after reset, then commit one word per request
  always_comb
  begin
    n = r;
    n.loadWe = 1'b0;
    unique case (r.ph)
      NV_LOAD:
      begin
        if (nvmAck)
        begin
          n.loadWe = 1'b1;
          n.data   = nvmRdata;
          n.req    = 1'b0;
        end
        if (r.loadWe)
        begin
          if (r.addr == LAST_ADDR)
          begin
            n.ph   = NV_IDLE;
            n.busy = 1'b0;
          end
          else
          begin
            n.addr = r.addr + AW'(1);
            n.req  = 1'b1;
          end
        end
      end
      NV_IDLE:
      begin
        if (commitStart)
        begin
          n.ph    = NV_WRITE;
          n.req   = 1'b1;
          n.write = 1'b1;
          n.addr  = commitAddr;
          n.data  = commitData;
          n.busy  = 1'b1;
        end
      end
      NV_WRITE:
      begin
        if (nvmAck)
        begin
          n.ph    = NV_IDLE;
          n.req   = 1'b0;
          n.write = 1'b0;
          n.busy  = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      r <= RST_VAL;
    end
    else
    begin
      r <= n;
    end
  end

  assign busy     = r.busy;
  assign loadWe   = r.loadWe;
  assign loadAddr = r.addr;
  assign loadData = r.data;
  assign nvmReq   = r.req;
  assign nvmWrite = r.write;
  assign nvmAddr  = r.addr;
  assign nvmWdata = r.data;
endmodule : ssd_nvm_commit
`default_nettype wire

/* verilog/ssd_slave_dict.sv */
`default_nettype none
module ssd_slave_dict #(
  parameter int              NUM_CH      = 2,
  parameter int              SUB_PER_CH  = 4,
  parameter int              OUT_W       = 8,
  parameter int              IN_W        = 8,
  parameter logic [15:0]     CH_BASE     = ssd_pkg::IDX_CHAN_BASE,
  parameter logic [31:0]     DEVICE_TYPE = 32'h00000001, // arbitrary value
  parameter logic [31:0]     VENDOR_CODE = 32'h0000ABCD, // arbitrary value
  parameter logic [31:0]     PRODUCT_CODE = 32'h00001234, // arbitrary value
  parameter int              DEPTH       = NUM_CH * SUB_PER_CH,
  parameter int              AW          = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         reset,
  // state requests
  input  wire logic                         stReq,
  input  wire ssd_pkg::ssd_state_t          stReqState,
  output ssd_pkg::ssd_state_t               stateNow,
  output logic                              stAck,
  output logic                              stErr,
  // process data
  input  wire logic                         pdOutValid,
  input  wire logic [OUT_W-1:0]             pdOutData,
  input  wire logic [IN_W-1:0]              physIn,
  input  wire logic                         wdDisable,
  output logic      [OUT_W-1:0]             physOut,
  output logic      [IN_W-1:0]              pdInData,
  output logic                              pdRefused,
  // mailbox
  input  wire logic                         mbxReq,
  input  wire logic                         mbxFileXfer,
  input  wire logic                         mbxWrite,
  input  wire logic [ssd_pkg::IDX_W-1:0]    mbxIndex,
  input  wire logic [ssd_pkg::SUB_W-1:0]    mbxSub,
  input  wire logic [ssd_pkg::DATA_W-1:0]   mbxWdata,
  output logic                              mbxReady,
  output logic                              mbxDone,
  output logic                              mbxAbort,
  output logic      [ssd_pkg::DATA_W-1:0]   mbxRdata,
  // nonvolatile memory
  output logic                              nvmReq,
  output logic                              nvmWrite,
  output logic      [AW-1:0]                nvmAddr,
  output logic      [ssd_pkg::DATA_W-1:0]   nvmWdata,
  input  wire logic                         nvmAck,
  input  wire logic [ssd_pkg::DATA_W-1:0]   nvmRdata
);
  import ssd_pkg::*;

  typedef struct packed {
    ssd_state_t         st;
    logic               pdSeen;
    logic [OUT_W-1:0]   physOut;
    logic [OUT_W-1:0]   lastOut;
    logic [IN_W-1:0]    pdIn;
    logic               stAck;
    logic               stErr;
    logic               pdRefused;
    logic               mbxReady;
    logic               respPend;
    logic               respAbort;
    logic               respWrite;
    ssd_kind_t          respKind;
    logic [DATA_W-1:0]  respConst;
    logic               mbxDone;
    logic               mbxAbort;
    logic [DATA_W-1:0]  mbxRdata;
    logic [DATA_W-1:0]  saveCode;
    logic               suppress;
  } ssd_main_t;

  localparam ssd_main_t RST_VAL = '{st: SSD_RESET_STATE, respKind: SSD_K_NONE,
                                    saveCode: SAVE_CODE_RST, default: '0};
  localparam logic [OUT_W-1:0] OUT_SAFE = {OUT_W{OUT_SAFE_LEVEL}};

  //====================================================================
  // dictionary decode
  function automatic ssd_entry_t decodeEntry(input logic [IDX_W-1:0] idx,
                                             input logic [SUB_W-1:0] sub);
    logic [IDX_W-1:0] off;
    ssd_entry_t       e;
    off = idx - CH_BASE;
    e   = '{kind: SSD_K_NONE, slot: '0, value: '0};
    if (idx == IDX_DEV_TYPE && sub == SUB_ZERO) // RL10
      e = '{kind: SSD_K_CONST, slot: '0, value: DEVICE_TYPE};
    else if (idx == IDX_IDENTITY && sub == SUB_VENDOR)
      e = '{kind: SSD_K_CONST, slot: '0, value: VENDOR_CODE};
    else if (idx == IDX_IDENTITY && sub == SUB_PRODUCT)
      e = '{kind: SSD_K_CONST, slot: '0, value: PRODUCT_CODE};
    else if ((idx == IDX_OUT_MAP || idx == IDX_IN_MAP) && sub == SUB_ZERO)
      e = '{kind: SSD_K_CONST, slot: '0, value: PD_MAP_COUNT};
    else if (idx == IDX_PD_IN_BASE && sub == SUB_PD_VALUE) // RL12
      e = '{kind: SSD_K_PD_IN, slot: '0, value: '0};
    else if (idx == IDX_PD_OUT_BASE && sub == SUB_PD_VALUE)
      e = '{kind: SSD_K_PD_OUT, slot: '0, value: '0};
    else if (idx == IDX_SAVE_CTRL && sub == SUB_ZERO) // RL15
      e = '{kind: SSD_K_SAVE_CODE, slot: '0, value: '0};
    else if (off < IDX_W'(NUM_CH << CHAN_SHIFT) && off[CHAN_SHIFT-1:0] == '0 // RL11 RL13
             && sub >= SUB_CHAN_FIRST && sub < SUB_CHAN_FIRST + 8'(SUB_PER_CH)) // RL8
      e = '{kind: SSD_K_CHAN,
            slot: 8'(off >> CHAN_SHIFT) * 8'(SUB_PER_CH) + (sub - SUB_CHAN_FIRST),
            value: '0};
    return e;
  endfunction : decodeEntry

  function automatic logic legalMove(input ssd_state_t from, input ssd_state_t to,
                                     input logic seen);
    logic ok;
    ok = (to == from) || (to == SSD_INIT_STATE);
    unique case (from)
      SSD_INIT_STATE:         ok = ok || (to inside {SSD_MAILBOX_ONLY_STATE,
                                                     SSD_FW_UPDATE_STATE}); // RL6
      SSD_MAILBOX_ONLY_STATE: ok = ok || (to == SSD_GUARDED_RUN_STATE);
      SSD_GUARDED_RUN_STATE:  ok = ok || (to == SSD_MAILBOX_ONLY_STATE)
                                      || (to == SSD_RUNNING_STATE && seen); // RL4
      SSD_RUNNING_STATE:      ok = ok || (to inside {SSD_MAILBOX_ONLY_STATE,
                                                     SSD_GUARDED_RUN_STATE});
      SSD_FW_UPDATE_STATE:    ok = ok;
    endcase
    return ok;
  endfunction : legalMove

  //====================================================================
  // request qualification
  ssd_main_t         r;
  ssd_main_t         n;
  ssd_entry_t        ent;
  logic              take;
  logic              paramOk;
  logic              fileOk;
  logic              legal;
  logic              mbxRamWe;
  logic              commitStart;
  logic              nvmBusy;
  logic              loadWe;
  logic [AW-1:0]     loadAddr;
  logic [DATA_W-1:0] loadData;
  logic [DATA_W-1:0] ramRdata;
  logic              pdAccept;

  assign ent      = decodeEntry(mbxIndex, mbxSub);
  assign take     = mbxReq && r.mbxReady;
  assign paramOk  = !mbxFileXfer && (r.st inside {SSD_MAILBOX_ONLY_STATE, // RL1 RL2 RL5
                                                  SSD_GUARDED_RUN_STATE, SSD_RUNNING_STATE});
  assign fileOk   = mbxFileXfer && r.st == SSD_FW_UPDATE_STATE; // RL7
  assign legal    = fileOk || (paramOk && ent.kind != SSD_K_NONE // RL19
                    && (!mbxWrite || ent.kind inside {SSD_K_CHAN, SSD_K_SAVE_CODE})); // RL9
  assign mbxRamWe = take && legal && paramOk && mbxWrite && ent.kind == SSD_K_CHAN;
  assign commitStart = mbxRamWe && !r.suppress; // RL14 RL16
  assign pdAccept = r.st inside {SSD_GUARDED_RUN_STATE, SSD_RUNNING_STATE}; // RL1 RL7

  //====================================================================
  // state machine, process data and mailbox
  always_comb
  begin
    n           = r;
    n.stAck     = 1'b0;
    n.stErr     = 1'b0;
    n.pdRefused = pdOutValid && !pdAccept;
    n.mbxDone   = 1'b0;
    n.respPend  = 1'b0;
    if (stReq)
    begin
      if (legalMove(r.st, stReqState, r.pdSeen))
      begin
        n.st    = stReqState;
        n.stAck = 1'b1;
      end
      else
      begin
        n.stErr = 1'b1;
      end
    end
    if (pdAccept)
    begin
      n.pdIn = physIn; // RL2
      if (pdOutValid)
      begin
        n.lastOut = pdOutData;
        n.pdSeen  = r.st == SSD_GUARDED_RUN_STATE;
      end
    end
    if (n.st != r.st)
    begin
      n.pdSeen = 1'b0;
    end
    if (r.st == SSD_RUNNING_STATE || (r.st == SSD_GUARDED_RUN_STATE && wdDisable)) // RL3
    begin
      if (pdOutValid)
      begin
        n.physOut = pdOutData; // RL5
      end
    end
    else
    begin
      n.physOut = OUT_SAFE; // RL2
    end
    if (take)
    begin
      n.respPend  = 1'b1;
      n.respAbort = !legal; // RL19
      n.respWrite = mbxWrite;
      n.respKind  = fileOk ? SSD_K_NONE : ent.kind;
      n.respConst = ent.value;
      if (legal && paramOk && mbxWrite && ent.kind == SSD_K_SAVE_CODE)
      begin
        n.saveCode = mbxWdata;
        n.suppress = mbxWdata == SAVE_CODE_WORD; // RL15
      end
    end
    if (r.respPend)
    begin
      n.mbxDone  = 1'b1;
      n.mbxAbort = r.respAbort;
      n.mbxRdata = '0;
      if (!r.respAbort && !r.respWrite)
      begin
        unique case (r.respKind)
          SSD_K_NONE:      n.mbxRdata = '0;
          SSD_K_CONST:     n.mbxRdata = r.respConst;
          SSD_K_CHAN:      n.mbxRdata = ramRdata;
          SSD_K_PD_IN:     n.mbxRdata = DATA_W'(r.pdIn);
          SSD_K_PD_OUT:    n.mbxRdata = DATA_W'(r.lastOut);
          SSD_K_SAVE_CODE: n.mbxRdata = r.saveCode;
          default:         n.mbxRdata = '0;
        endcase
      end
    end
    n.mbxReady = !take && !nvmBusy;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      r <= RST_VAL;
    end
    else
    begin
      r <= n;
    end
  end

  //====================================================================
  // parameter storage
  ssd_param_ram #(.DW(DATA_W), .DEPTH(DEPTH)) uRam (
    .clk   (clk),
    .reset (reset),
    .we    (mbxRamWe || loadWe),
    .waddr (loadWe ? loadAddr : AW'(ent.slot)),
    .wdata (loadWe ? loadData : mbxWdata),
    .raddr (AW'(ent.slot)),
    .rdata (ramRdata)
  );

  ssd_nvm_commit #(.DW(DATA_W), .DEPTH(DEPTH)) uNvm (
    .clk         (clk),
    .reset       (reset),
    .commitStart (commitStart),
    .commitAddr  (AW'(ent.slot)),
    .commitData  (mbxWdata),
    .busy        (nvmBusy),
    .loadWe      (loadWe),
    .loadAddr    (loadAddr),
    .loadData    (loadData),
    .nvmReq      (nvmReq),
    .nvmWrite    (nvmWrite),
    .nvmAddr     (nvmAddr),
    .nvmWdata    (nvmWdata),
    .nvmAck      (nvmAck),
    .nvmRdata    (nvmRdata)
  );

  assign stateNow  = r.st;
  assign stAck     = r.stAck;
  assign stErr     = r.stErr;
  assign physOut   = r.physOut;
  assign pdInData  = r.pdIn;
  assign pdRefused = r.pdRefused;
  assign mbxReady  = r.mbxReady;
  assign mbxDone   = r.mbxDone;
  assign mbxAbort  = r.mbxAbort;
  assign mbxRdata  = r.mbxRdata;

  //====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  init_mbx_refuse_a: assert property ( // RL1
    take && r.st == SSD_INIT_STATE |-> ##2 mbxDone && mbxAbort)
    else $error("mailbox taken in initial state");
  pd_refused_a: assert property ( // RL1
    pdOutValid && !pdAccept |=> pdRefused && physOut == OUT_SAFE)
    else $error("process data not refused");
  guard_safe_a: assert property ( // RL2
    r.st == SSD_GUARDED_RUN_STATE && !wdDisable |=> physOut == OUT_SAFE)
    else $error("outputs not safe in guarded run");
  wd_off_copy_a: assert property ( // RL3
    r.st == SSD_GUARDED_RUN_STATE && wdDisable && pdOutValid |=> physOut == $past(pdOutData))
    else $error("outputs not driven with watchdog off");
  run_copy_a: assert property ( // RL5
    r.st == SSD_RUNNING_STATE && pdOutValid |=> physOut == $past(pdOutData))
    else $error("outputs not copied in running");
  fw_entry_a: assert property ( // RL6
    $rose(r.st == SSD_FW_UPDATE_STATE) |-> $past(r.st) == SSD_INIT_STATE)
    else $error("firmware update entered from wrong state");
  fw_only_file_a: assert property ( // RL7
    take && r.st == SSD_FW_UPDATE_STATE && !mbxFileXfer |-> ##2 mbxDone && mbxAbort)
    else $error("non file mailbox accepted in update");
  ro_write_a: assert property ( // RL19
    take && mbxWrite && ent.kind == SSD_K_CONST |-> !mbxRamWe ##2 mbxDone && mbxAbort)
    else $error("read only entry written");
  chan_commit_a: assert property ( // RL14
    mbxRamWe && !r.suppress |=> nvmReq && nvmWrite && nvmWdata == $past(mbxWdata))
    else $error("parameter not committed");
  suppress_save_a: assert property ( // RL16
    mbxRamWe && r.suppress |=> !nvmReq [*2])
    else $error("save not suppressed");
  code_word_a: assert property ( // RL15
    take && legal && paramOk && mbxWrite && ent.kind == SSD_K_SAVE_CODE
    |=> r.suppress == ($past(mbxWdata) == SAVE_CODE_WORD))
    else $error("code word switch wrong");

  run_reach_c: cover property ($rose(r.st == SSD_RUNNING_STATE));
  fw_reach_c: cover property ($rose(r.st == SSD_FW_UPDATE_STATE));
  suppress_on_c: cover property ($rose(r.suppress));
  commit_c: cover property (commitStart ##1 nvmReq [*2] ##1 !nvmReq);
endmodule : ssd_slave_dict
`default_nettype wire

/* sim/ssd_nvm_model.sv */
`default_nettype none
//==========
// nonvolatile memory behind the dictionary
module ssd_nvm_model #(
  parameter int DLY = 2
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // request side
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [2:0]  addr,
  input  wire logic [31:0] wdata,
  output logic             ack,
  output logic      [31:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [8];
  int          cnt;
  int          nWr;
  initial
  begin
    for (int i = 0; i < 8; i++)
      mem[i] = 32'hA0000000 + i;
    nWr   = 0;
    rdata = 32'h0;
  end
  // content survives reset; data line toggles except when answering a read
  always @(posedge clk or posedge reset)
  begin
    ack   <= 1'b0;
    rdata <= ~rdata;
    if (reset)
      cnt <= 0;
    else if (req && !ack && cnt < DLY)
      cnt <= cnt + 1;
    else if (req && !ack)
    begin
      cnt <= 0;
      ack <= 1'b1;
      if (wr)
      begin
        mem[addr] <= wdata;
        nWr       <= nWr + 1;
      end
      else
        rdata <= mem[addr];
    end
  end
endmodule : ssd_nvm_model
`default_nettype wire

/* sim/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssd_pkg::*;
  localparam logic [31:0] DEV_T = 32'h00000011; // arbitrary value
  localparam logic [31:0] VEN   = 32'h0000BEEF; // arbitrary value
  localparam logic [15:0] CH1   = IDX_CHAN_BASE + 16'h0010;
  logic        clk, reset, stReq, stAck, stErr, pdOutValid, wdDisable, pdRefused;
  logic        mbxReq, mbxFileXfer, mbxWrite, mbxReady, mbxDone, mbxAbort;
  logic        nvmReq, nvmWrite, nvmAck;
  ssd_state_t  stReqState, stateNow;
  logic [7:0]  pdOutData, physIn, physOut, pdInData, mbxSub;
  logic [15:0] mbxIndex;
  logic [31:0] mbxWdata, mbxRdata, nvmWdata, nvmRdata;
  logic [2:0]  nvmAddr;
  int          nFail, nTests, nw;

  ssd_slave_dict #(.DEVICE_TYPE(DEV_T), .VENDOR_CODE(VEN)) ssd_slave_dict_i (.clk, .reset,
    .stReq, .stReqState, .stateNow, .stAck, .stErr, .pdOutValid, .pdOutData, .physIn,
    .wdDisable, .physOut, .pdInData, .pdRefused, .mbxReq, .mbxFileXfer, .mbxWrite, .mbxIndex,
    .mbxSub, .mbxWdata, .mbxReady, .mbxDone, .mbxAbort, .mbxRdata, .nvmReq, .nvmWrite,
    .nvmAddr, .nvmWdata, .nvmAck, .nvmRdata);
  ssd_nvm_model ssd_nvm_model_i (.clk, .reset, .req(nvmReq), .wr(nvmWrite), .addr(nvmAddr),
    .wdata(nvmWdata), .ack(nvmAck), .rdata(nvmRdata));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  //==========
  // shared tasks
  task automatic end_sim();
    if (nFail == 0 && nTests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    nTests++;
    if (g !== e)
    begin
      nFail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic waitRdy();
    int i;
    for (i = 0; i < 600 && mbxReady !== 1'b1; i++)
      tick();
    if (i == 600)
    begin
      nFail++;
      end_sim();
    end
  endtask : waitRdy
  task automatic st(ssd_state_t s, logic ok);
    logic a, e;
    stReq      = 1'b1;
    stReqState = s;
    tick();
    stReq = 1'b0;
    a     = stAck;
    e     = stErr;
    tick();
    chk("stAck", ok, a | stAck);
    chk("stErr", !ok, e | stErr);
    if (ok)
      chk("stateNow", s, stateNow);
  endtask : st
  task automatic pd(logic [7:0] d, logic [7:0] o, logic r);
    logic f;
    pdOutValid = 1'b1;
    pdOutData  = d;
    tick();
    pdOutValid = 1'b0;
    pdOutData  = ~d;
    f          = pdRefused;
    tick();
    chk("pdRefused", r, f | pdRefused);
    chk("physOut", o, physOut);
  endtask : pd
  task automatic mb(logic fx, logic wr, logic [15:0] ix, logic [7:0] sb, logic [31:0] wd,
                    logic ab, logic [31:0] rd);
    int i;
    waitRdy();
    {mbxReq, mbxFileXfer, mbxWrite, mbxIndex, mbxSub, mbxWdata} = {1'b1, fx, wr, ix, sb, wd};
    tick();
    mbxReq   = 1'b0;
    mbxWdata = ~wd;
    for (i = 0; i < 4 && mbxDone !== 1'b1; i++)
      tick();
    chk("mbxDone", 1, mbxDone);
    chk("mbxAbort", ab, mbxAbort);
    chk("mbxRdata", rd, mbxRdata);
  endtask : mb
  task automatic doReset();
    reset = 1'b1;
    repeat (6) tick();
    reset = 1'b0;
    chk("stateNow", SSD_INIT_STATE, stateNow);
    waitRdy();
  endtask : doReset

  //==========
  // scenarios
  task automatic t_fw();
    mb(0, 0, IDX_DEV_TYPE, SUB_ZERO, 0, 1, 0);
    pd(8'hA5, 8'h00, 1);
    st(SSD_MAILBOX_ONLY_STATE, 1);
    st(SSD_FW_UPDATE_STATE, 0);
    st(SSD_INIT_STATE, 1);
    st(SSD_FW_UPDATE_STATE, 1);
    mb(1, 1, 0, 0, 32'h55, 0, 0);
    mb(0, 0, IDX_DEV_TYPE, SUB_ZERO, 0, 1, 0);
    pd(8'h5A, 8'h00, 1);
    st(SSD_MAILBOX_ONLY_STATE, 0);
    st(SSD_INIT_STATE, 1);
  endtask : t_fw
  task automatic t_run();
    st(SSD_MAILBOX_ONLY_STATE, 1);
    mb(1, 0, 0, 0, 0, 1, 0);
    st(SSD_GUARDED_RUN_STATE, 1);
    st(SSD_RUNNING_STATE, 0);
    pd(8'hA5, 8'h00, 0);
    chk("pdInData", 8'h3C, pdInData);
    wdDisable = 1'b1;
    pd(8'h96, 8'h96, 0);
    wdDisable = 1'b0;
    tick();
    chk("physOut", 8'h00, physOut);
    st(SSD_RUNNING_STATE, 1);
    pd(8'hC3, 8'hC3, 0);
    physIn = 8'h81;
    tick();
    tick();
    chk("pdInData", 8'h81, pdInData);
    mb(0, 0, IDX_PD_OUT_BASE, SUB_PD_VALUE, 0, 0, 32'hC3);
    mb(0, 0, IDX_PD_IN_BASE, SUB_PD_VALUE, 0, 0, 32'h81);
  endtask : t_run
  task automatic t_dict();
    mb(0, 0, IDX_IDENTITY, SUB_VENDOR, 0, 0, VEN);
    mb(0, 1, IDX_IDENTITY, SUB_VENDOR, 32'h1, 1, 0);
    mb(0, 0, IDX_IDENTITY, SUB_VENDOR, 0, 0, VEN);
    mb(0, 1, IDX_DEV_TYPE, SUB_ZERO, 32'h7, 1, 0);
    mb(0, 0, 16'hFFFF, 8'hFF, 0, 1, 0);
    mb(0, 0, CH1, 8'h09, 0, 1, 0);
    mb(0, 0, CH1, 8'h02, 0, 0, 32'hA0000005);
    nw = ssd_nvm_model_i.nWr;
    mb(0, 1, CH1, 8'h02, 32'h11223344, 0, 0);
    mb(0, 0, CH1, 8'h02, 0, 0, 32'h11223344);
    chk("nvmMem", 32'h11223344, ssd_nvm_model_i.mem[5]);
    chk("nvmWrites", nw + 1, ssd_nvm_model_i.nWr);
    mb(0, 1, IDX_SAVE_CTRL, SUB_ZERO, SAVE_CODE_WORD, 0, 0);
    mb(0, 1, IDX_CHAN_BASE, SUB_CHAN_FIRST, 32'hCAFE0001, 0, 0);
    mb(0, 0, IDX_CHAN_BASE, SUB_CHAN_FIRST, 0, 0, 32'hCAFE0001);
    chk("nvmWrites", nw + 1, ssd_nvm_model_i.nWr);
  endtask : t_dict
  task automatic t_boot();
    doReset();
    mb(0, 0, IDX_CHAN_BASE, SUB_CHAN_FIRST, 0, 1, 0);
    st(SSD_MAILBOX_ONLY_STATE, 1);
    mb(0, 0, IDX_SAVE_CTRL, SUB_ZERO, 0, 0, SAVE_CODE_RST);
    mb(0, 0, IDX_CHAN_BASE, SUB_CHAN_FIRST, 0, 0, 32'hA0000000);
    mb(0, 0, CH1, 8'h02, 0, 0, 32'h11223344);
    mb(0, 1, IDX_CHAN_BASE, SUB_CHAN_FIRST, 32'h5, 0, 0);
    waitRdy();
    chk("nvmWrites", nw + 2, ssd_nvm_model_i.nWr);
  endtask : t_boot

  initial
  begin
    {reset, stReq, pdOutValid, wdDisable, mbxReq, mbxFileXfer, mbxWrite} = '0;
    stReqState = SSD_INIT_STATE;
    {pdOutData, mbxIndex, mbxSub, mbxWdata} = '0;
    physIn = 8'h3C;
    nFail  = 0;
    nTests = 0;
    #1;
    doReset();
    t_fw();
    t_run();
    t_dict();
    t_boot();
    end_sim();
  end
endmodule : tb
`default_nettype wire
